// [verilog/lbit_map.svh]
`ifndef LBIT_MAP_SVH
`define LBIT_MAP_SVH

// I/O addresses of the lower register space
`define LBIT_A_PWR      6'h00
`define LBIT_A_DIDR     6'h01
`define LBIT_A_CNVLO    6'h04
`define LBIT_A_T1FLG    6'h0b
`define LBIT_A_T1MSK    6'h0c
`define LBIT_A_USICTL   6'h0d
`define LBIT_A_USISTA   6'h0e
`define LBIT_A_USIDAT   6'h0f
`define LBIT_A_USIBUF   6'h10
`define LBIT_A_RSVD11   6'h11
`define LBIT_A_PCMASK   6'h12
`define LBIT_A_SCR0     6'h13
`define LBIT_A_SCR1     6'h14
`define LBIT_A_SCR2     6'h15
`define LBIT_A_PBIN     6'h16
`define LBIT_A_PBDIR    6'h17
`define LBIT_A_PBOUT    6'h18
`define LBIT_A_PAIN     6'h19
`define LBIT_A_PADIR    6'h1a
`define LBIT_A_PAOUT    6'h1b
`define LBIT_A_NVMCTL   6'h1c

// Highest address reachable by the single-bit instructions
`define LBIT_BIT_TOP    6'h1f

// Writable bit masks (set bits are implemented, others read zero)
`define LBIT_RW_FULL    8'hff
`define LBIT_RW_NONE    8'h00
`define LBIT_RW_PWR     8'h0f
`define LBIT_RW_T1MSK   8'h27
`define LBIT_RW_USICTL  8'hfc
`define LBIT_RW_USISTA  8'h0f
`define LBIT_RW_PB      8'h0f
`define LBIT_RW_NVMCTL  8'h3f

// Write-one-to-clear flag masks
`define LBIT_W1C_T1FLG  8'h27
`define LBIT_W1C_USISTA 8'he0

// USI strobe bits, count-done bit position, reset value
`define LBIT_USI_STB    2'h3
`define LBIT_DONE_BIT   4
`define LBIT_RST_VAL    8'h00
`define LBIT_ZERO4      4'h0
`define LBIT_ZERO8      8'h00

`endif

// [verilog/lbit_pkg.sv]
package lbit_pkg;

  // Kind of access the core makes this cycle
  typedef enum logic [1:0]
  {
    LBIT_OP_NONE  = 2'b00,
    LBIT_OP_WRITE = 2'b01,
    LBIT_OP_SET   = 2'b10,
    LBIT_OP_CLR   = 2'b11
  } lbit_op_type;

endpackage : lbit_pkg

// [verilog/lbit_op_dec.sv]
`include "lbit_map.svh"

// Turns a byte write or single-bit access into a write mask and value
module lbit_op_dec
(
  input  logic                  wr_i,       // Whole-byte write
  input  logic                  set_i,      // Single-bit set
  input  logic                  clr_i,      // Single-bit clear
  input  logic [5:0]            addr_i,     // I/O address
  input  logic [2:0]            bit_i,      // Bit number
  input  logic [7:0]            wdata_i,    // Byte write data
  output lbit_pkg::lbit_op_type op_o,       // Decoded access
  output logic                  in_range_o, // Address is bit-accessible
  output logic [7:0]            mask_o,     // Bits touched by the access
  output logic [7:0]            val_o       // Value written to touched bits
);

  logic [7:0] one_hot; // Selected bit as a mask

  // Byte write wins over bit ops; bit ops above the range do nothing
  always_comb
  begin
    one_hot    = 8'h01 << bit_i;
    in_range_o = (addr_i <= `LBIT_BIT_TOP);
    op_o       = lbit_pkg::LBIT_OP_NONE;
    mask_o     = `LBIT_ZERO8;
    val_o      = `LBIT_ZERO8;
    if (wr_i)
    begin
      op_o   = lbit_pkg::LBIT_OP_WRITE;
      mask_o = `LBIT_RW_FULL;
      val_o  = wdata_i;
    end
    else if (set_i && in_range_o)
    begin
      op_o   = lbit_pkg::LBIT_OP_SET;
      mask_o = one_hot;
      val_o  = one_hot;
    end
    else if (clr_i && in_range_o)
    begin
      op_o   = lbit_pkg::LBIT_OP_CLR;
      mask_o = one_hot;
      val_o  = `LBIT_ZERO8;
    end
  end

endmodule : lbit_op_dec

// [verilog/lbit_reg.sv]
`include "lbit_map.svh"

// One 8-bit register with plain, write-one-to-clear and reserved bits
module lbit_reg
#(
  parameter logic [7:0] RW_MASK  = `LBIT_RW_FULL,  // Plain read/write bits
  parameter logic [7:0] W1C_MASK = `LBIT_RW_NONE,  // Flags cleared by a one
  parameter logic [7:0] RST_VAL  = `LBIT_RST_VAL   // Value after reset
)
(
  input  logic       clk_i,     // System clock
  input  logic       rstn_i,    // Async reset, active low
  input  logic       sel_i,     // Address matches this register
  input  logic [7:0] wr_mask_i, // Bits touched by the access
  input  logic [7:0] wr_val_i,  // Value for touched bits
  input  logic [7:0] hw_set_i,  // Flag set pulses from the peripheral
  output logic [7:0] q_o        // Current contents
);

  logic [7:0] q_q; // Stored value
  logic [7:0] q_d; // Next value
  logic [7:0] wm;  // Effective touched bits

  // Next value: merge plain bits, clear flags written one, then let sets win
  always_comb
  begin
    wm  = sel_i ? wr_mask_i : `LBIT_ZERO8;
    q_d = (q_q & ~(wm & RW_MASK)) | (wr_val_i & wm & RW_MASK);
    q_d = q_d & ~(wm & wr_val_i & W1C_MASK);
    q_d = q_d | (hw_set_i & W1C_MASK);
    q_d = q_d & (RW_MASK | W1C_MASK);
  end

  // Register only
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_q <= RST_VAL;
    else
      q_q <= q_d;
  end

  assign q_o = q_q;

endmodule : lbit_reg

// [verilog/lbit_io_space.sv]
// What this block does
// - Set and clear bits at 0x00-0x1F
// - Bit tests sample without altering register
// - Some status flags clear on writing one
// - Bit op touches only the addressed bit
// - Bit ops above 0x1F have no effect
`include "lbit_map.svh"

module lbit_io_space
(
  input  logic       CLK_I,            // System clock, 40 MHz
  input  logic       RSTN_I,           // Async reset, active low
  input  logic [5:0] IO_ADDR_I,        // I/O address from the core
  input  logic       IO_WR_I,          // Byte write strobe
  input  logic       IO_RD_I,          // Byte read strobe
  input  logic       IO_SET_I,         // Single-bit set strobe
  input  logic       IO_CLR_I,         // Single-bit clear strobe
  input  logic       IO_TEST_I,        // Single-bit test strobe
  input  logic [2:0] IO_BIT_I,         // Bit number for bit ops
  input  logic [7:0] IO_WDATA_I,       // Byte write data
  output logic [7:0] IO_RDATA_O,       // Read data, one cycle after read
  output logic       IO_BITVAL_O,      // Tested bit, one cycle after test
  input  logic [7:0] PA_PINS_I,        // Port A pin levels
  input  logic [3:0] PB_PINS_I,        // Port B pin levels
  input  logic [7:0] ADC_RES_LOW_I,    // Converter result low byte
  input  logic [7:0] USI_BUF_I,        // Serial buffer contents
  input  logic       USI_DONE_I,       // Serial count-done status level
  input  logic [7:0] TMR1_FLAG_SET_I,  // Timer1 flag set pulses
  input  logic [7:0] USI_FLAG_SET_I,   // Serial flag set pulses
  output logic [7:0] PA_OUT_O,         // Port A output data
  output logic [7:0] PA_DIR_O,         // Port A direction
  output logic [7:0] PB_OUT_O,         // Port B output data
  output logic [7:0] PB_DIR_O,         // Port B direction
  output logic [7:0] PWR_RED_O,        // Power reduction bits
  output logic [7:0] DIG_IN_DIS_O,     // Digital input disable bits
  output logic [7:0] TMR1_MASK_O,      // Timer1 interrupt mask
  output logic [7:0] TMR1_FLAGS_O,     // Timer1 interrupt flags
  output logic [7:0] USI_CTRL_O,       // Serial control
  output logic [7:0] USI_STAT_O,       // Serial status (stored part)
  output logic [7:0] USI_DATA_O,       // Serial shift data
  output logic [1:0] USI_STROBE_O,     // Serial clock/toggle strobes, pulse
  output logic [7:0] PC_MASK_O,        // Pin change mask
  output logic [7:0] NVM_CTRL_O        // Non-volatile memory control
);

  lbit_pkg::lbit_op_type op;       // Decoded access kind
  logic                  in_range; // Address is bit-accessible
  logic [7:0]            wr_mask;  // Bits touched
  logic [7:0]            wr_val;   // Values for touched bits
  logic [7:0]            scr0_q;   // Scratch storage 0
  logic [7:0]            scr1_q;   // Scratch storage 1
  logic [7:0]            scr2_q;   // Scratch storage 2
  logic [7:0]            rd_mux;   // Value at the current address
  logic [7:0]            rdata_q;  // Registered read data
  logic [7:0]            rdata_d;
  logic                  bitval_q; // Registered tested bit
  logic                  bitval_d;
  logic [1:0]            stb_q;    // Registered serial strobes
  logic [1:0]            stb_d;

  // Access decode shared by all registers
  lbit_op_dec u_dec
  (
    .wr_i(IO_WR_I), .set_i(IO_SET_I), .clr_i(IO_CLR_I), .addr_i(IO_ADDR_I),
    .bit_i(IO_BIT_I), .wdata_i(IO_WDATA_I), .op_o(op), .in_range_o(in_range),
    .mask_o(wr_mask), .val_o(wr_val)
  );

  // Power reduction, low nibble only
  lbit_reg #(.RW_MASK(`LBIT_RW_PWR)) u_pwr
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PWR), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PWR_RED_O));

  // Digital input disable
  lbit_reg u_didr
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_DIDR), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(DIG_IN_DIS_O));

  // Timer1 flags: only cleared by a one, set by the timer
  lbit_reg #(.RW_MASK(`LBIT_RW_NONE), .W1C_MASK(`LBIT_W1C_T1FLG)) u_t1flg
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_T1FLG), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(TMR1_FLAG_SET_I), .q_o(TMR1_FLAGS_O));

  // Timer1 mask
  lbit_reg #(.RW_MASK(`LBIT_RW_T1MSK)) u_t1msk
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_T1MSK), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(TMR1_MASK_O));

  // Serial control; the two strobe bits are not stored and read zero
  lbit_reg #(.RW_MASK(`LBIT_RW_USICTL)) u_usictl
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_USICTL), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(USI_CTRL_O));

  // Serial status: three flags plus a plain counter nibble
  lbit_reg #(.RW_MASK(`LBIT_RW_USISTA), .W1C_MASK(`LBIT_W1C_USISTA)) u_usista
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_USISTA), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(USI_FLAG_SET_I), .q_o(USI_STAT_O));

  // Serial shift data; shifting itself lives in the serial block
  lbit_reg u_usidat
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_USIDAT), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(USI_DATA_O));

  // Pin change mask
  lbit_reg u_pcmsk
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PCMASK), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PC_MASK_O));

  // Scratch storage, three bytes
  lbit_reg u_scr0
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_SCR0), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(scr0_q));
  lbit_reg u_scr1
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_SCR1), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(scr1_q));
  lbit_reg u_scr2
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_SCR2), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(scr2_q));

  // Port B: four pins, upper nibble reserved
  lbit_reg #(.RW_MASK(`LBIT_RW_PB)) u_pbdir
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PBDIR), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PB_DIR_O));
  lbit_reg #(.RW_MASK(`LBIT_RW_PB)) u_pbout
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PBOUT), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PB_OUT_O));

  // Port A: full byte
  lbit_reg u_padir
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PADIR), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PA_DIR_O));
  lbit_reg u_paout
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_PAOUT), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(PA_OUT_O));

  // Non-volatile memory control, two top bits reserved
  lbit_reg #(.RW_MASK(`LBIT_RW_NVMCTL)) u_nvmctl
  (.clk_i(CLK_I), .rstn_i(RSTN_I), .sel_i(IO_ADDR_I == `LBIT_A_NVMCTL), .wr_mask_i(wr_mask),
   .wr_val_i(wr_val), .hw_set_i(`LBIT_ZERO8), .q_o(NVM_CTRL_O));

  // Read view of the current address; reserved places read zero
  always_comb
  begin
    case (IO_ADDR_I)
      `LBIT_A_PWR    : rd_mux = PWR_RED_O;
      `LBIT_A_DIDR   : rd_mux = DIG_IN_DIS_O;
      `LBIT_A_CNVLO  : rd_mux = ADC_RES_LOW_I;
      `LBIT_A_T1FLG  : rd_mux = TMR1_FLAGS_O;
      `LBIT_A_T1MSK  : rd_mux = TMR1_MASK_O;
      `LBIT_A_USICTL : rd_mux = USI_CTRL_O;
      `LBIT_A_USISTA : // Count-done is a live status bit
      begin
        rd_mux                  = USI_STAT_O;
        rd_mux[`LBIT_DONE_BIT]  = USI_DONE_I;
      end
      `LBIT_A_USIDAT : rd_mux = USI_DATA_O;
      `LBIT_A_USIBUF : rd_mux = USI_BUF_I;
      `LBIT_A_PCMASK : rd_mux = PC_MASK_O;
      `LBIT_A_SCR0   : rd_mux = scr0_q;
      `LBIT_A_SCR1   : rd_mux = scr1_q;
      `LBIT_A_SCR2   : rd_mux = scr2_q;
      `LBIT_A_PBIN   : rd_mux = {`LBIT_ZERO4, PB_PINS_I};
      `LBIT_A_PBDIR  : rd_mux = PB_DIR_O;
      `LBIT_A_PBOUT  : rd_mux = PB_OUT_O;
      `LBIT_A_PAIN   : rd_mux = PA_PINS_I;
      `LBIT_A_PADIR  : rd_mux = PA_DIR_O;
      `LBIT_A_PAOUT  : rd_mux = PA_OUT_O;
      `LBIT_A_NVMCTL : rd_mux = NVM_CTRL_O;
      default        : rd_mux = `LBIT_ZERO8; // Reserved or out of this block
    endcase
  end

  // Next read data, tested bit and strobes; reads and tests never write
  always_comb
  begin
    rdata_d  = IO_RD_I ? rd_mux : rdata_q;
    bitval_d = bitval_q;
    if (IO_TEST_I)
      bitval_d = in_range ? rd_mux[IO_BIT_I] : 1'b0;
    // A one written to a strobe bit makes a single pulse
    if ((op != lbit_pkg::LBIT_OP_NONE) && (IO_ADDR_I == `LBIT_A_USICTL))
      stb_d = wr_mask[1:0] & wr_val[1:0] & `LBIT_USI_STB;
    else
      stb_d = 2'b00;
  end

  // Register only
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rdata_q  <= `LBIT_ZERO8;
      bitval_q <= 1'b0;
      stb_q    <= 2'b00;
    end
    else
    begin
      rdata_q  <= rdata_d;
      bitval_q <= bitval_d;
      stb_q    <= stb_d;
    end
  end

  assign IO_RDATA_O   = rdata_q;
  assign IO_BITVAL_O  = bitval_q;
  assign USI_STROBE_O = stb_q;

  // Checks, all in the system clock domain
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Lone bit set or clear on port A output, no byte write
  sequence s_pa_set;
    IO_SET_I && !IO_WR_I && (IO_ADDR_I == `LBIT_A_PAOUT);
  endsequence
  sequence s_pa_clr;
    IO_CLR_I && !IO_SET_I && !IO_WR_I && (IO_ADDR_I == `LBIT_A_PAOUT);
  endsequence
  // Quiet timer flags: no set pulses now
  sequence s_tmr_quiet;
    TMR1_FLAG_SET_I == `LBIT_ZERO8;
  endsequence
  // Quiet serial flags: no set pulses now
  sequence s_usi_quiet;
    USI_FLAG_SET_I == `LBIT_ZERO8;
  endsequence
  // Byte write or lone bit set on the serial status register
  sequence s_usi_wr;
    IO_WR_I && (IO_ADDR_I == `LBIT_A_USISTA);
  endsequence
  sequence s_usi_set;
    IO_SET_I && !IO_WR_I && (IO_ADDR_I == `LBIT_A_USISTA);
  endsequence

  a_bit_set_only: assert property (s_pa_set |=>
    PA_OUT_O == ($past(PA_OUT_O) | (8'h01 << $past(IO_BIT_I))))
    else $error("bit set changed wrong bits");

  a_bit_clr_only: assert property (s_pa_clr |=>
    PA_OUT_O == ($past(PA_OUT_O) & ~(8'h01 << $past(IO_BIT_I))))
    else $error("bit clear changed wrong bits");

  a_upper_ignored: assert property (
    (IO_SET_I || IO_CLR_I) && !IO_WR_I && (IO_ADDR_I > `LBIT_BIT_TOP)
    |=> $stable(PA_OUT_O) && $stable(TMR1_FLAGS_O) && $stable(NVM_CTRL_O))
    else $error("bit op above range had effect");

  a_flag_w1c: assert property (
    (IO_WR_I && (IO_ADDR_I == `LBIT_A_T1FLG)) and s_tmr_quiet
    |=> TMR1_FLAGS_O == ($past(TMR1_FLAGS_O) & ~$past(IO_WDATA_I)))
    else $error("flag write did not clear only ones");

  a_flag_bitop: assert property (
    (IO_CLR_I && !IO_SET_I && !IO_WR_I && (IO_ADDR_I == `LBIT_A_T1FLG)) and s_tmr_quiet
    |=> $stable(TMR1_FLAGS_O))
    else $error("bit clear disturbed pending flags");

  a_flag_set_wins: assert property (
    (TMR1_FLAG_SET_I & `LBIT_W1C_T1FLG) != `LBIT_ZERO8
    |=> (TMR1_FLAGS_O & $past(TMR1_FLAG_SET_I) & `LBIT_W1C_T1FLG)
        == ($past(TMR1_FLAG_SET_I) & `LBIT_W1C_T1FLG))
    else $error("flag set lost against clear");

  a_test_value: assert property (
    IO_TEST_I && (IO_ADDR_I == `LBIT_A_PAOUT) ##1 $stable(PA_OUT_O)
    |-> IO_BITVAL_O == PA_OUT_O[$past(IO_BIT_I)])
    else $error("tested bit wrong");

  a_test_no_write: assert property (
    IO_TEST_I && !IO_WR_I && !IO_SET_I && !IO_CLR_I
    |=> $stable(PA_OUT_O) && $stable(PB_DIR_O) && $stable(USI_DATA_O))
    else $error("bit test changed a register");

  a_rsvd_addr: assert property (
    IO_RD_I && (IO_ADDR_I == `LBIT_A_RSVD11) |=> IO_RDATA_O == `LBIT_ZERO8)
    else $error("reserved address not zero");

  // Zero bits of a byte write leave the serial flags pending
  a_usi_zero_keep: assert property (
    s_usi_wr and s_usi_quiet
    |=> (USI_STAT_O & `LBIT_W1C_USISTA & ~$past(IO_WDATA_I))
        == ($past(USI_STAT_O) & `LBIT_W1C_USISTA & ~$past(IO_WDATA_I)))
    else $error("zero write changed a serial flag");

  // A bit set on the serial status leaves the other flags pending
  a_usi_set_keep: assert property (
    s_usi_set and s_usi_quiet
    |=> (USI_STAT_O & `LBIT_W1C_USISTA & ~(8'h01 << $past(IO_BIT_I)))
        == ($past(USI_STAT_O) & `LBIT_W1C_USISTA & ~(8'h01 << $past(IO_BIT_I))))
    else $error("bit set disturbed other serial flags");

  // The tested bit stands until the next test, so the core may look late
  a_bitval_hold: assert property (
    !IO_TEST_I |=> $stable(IO_BITVAL_O))
    else $error("tested bit changed without a test");

  // A test above the bit-accessible range answers zero, never stale data
  a_test_upper: assert property (
    IO_TEST_I && (IO_ADDR_I > `LBIT_BIT_TOP) |=> !IO_BITVAL_O)
    else $error("bit test above range not zero");

  // Pin tests return the level seen at the test edge
  a_test_pins: assert property (
    IO_TEST_I && (IO_ADDR_I == `LBIT_A_PAIN)
    |=> ((($past(PA_PINS_I) >> $past(IO_BIT_I)) & 8'h01) == {7'h00, IO_BITVAL_O}))
    else $error("tested pin level wrong");

  a_rsvd_bits: assert property (
    IO_WR_I && (IO_ADDR_I == `LBIT_A_PBOUT) |=> PB_OUT_O[7:4] == `LBIT_ZERO4)
    else $error("reserved port bits stored");

endmodule : lbit_io_space

// [tb/lbit_core_model.sv]
`include "lbit_map.svh"

// Behavioural processor core issuing one I/O access at a time
module lbit_core_model
(
  input  logic       clk_i,    // System clock
  output logic [5:0] addr_o,   // I/O address
  output logic       wr_o,     // Byte write strobe
  output logic       rd_o,     // Byte read strobe
  output logic       set_o,    // Bit set strobe
  output logic       clr_o,    // Bit clear strobe
  output logic       test_o,   // Bit test strobe
  output logic [2:0] bit_o,    // Bit number
  output logic [7:0] wdata_o,  // Byte write data
  input  logic [7:0] rdata_i,  // Read data, one cycle after the read
  input  logic       bitval_i  // Tested bit, one cycle after the test
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet bus at time zero, so no strobe is unknown
  initial
  begin
    {wr_o, rd_o, set_o, clr_o, test_o} = 5'h00;
    addr_o = 6'h00;
    bit_o = 3'h0;
    wdata_o = 8'h00;
  end

  // Launch after an edge, hold through the taking edge, then retire
  task automatic access(input logic [5:0] a, input logic [2:0] b, input logic [7:0] d, input logic [4:0] k);
    @(posedge clk_i);
    #2;
    addr_o = a;
    bit_o = b;
    wdata_o = d;
    {wr_o, rd_o, set_o, clr_o, test_o} = k;
    @(posedge clk_i);
    #2;
    {wr_o, rd_o, set_o, clr_o, test_o} = 5'h00;
    // Data no longer qualified: show a changed pattern, not the stale byte
    wdata_o = ~d;
  endtask : access

  // Byte write; reserved address 0x11 is never written
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    if (a == `LBIT_A_RSVD11)
      return;
    access(a, 3'h0, d, 5'b10000);
  endtask : io_wr

  // Byte read, data taken right after the answer edge
  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    access(a, 3'h0, 8'h00, 5'b01000);
    d = rdata_i;
  endtask : io_rd

  // Single-bit set
  task automatic io_set(input logic [5:0] a, input logic [2:0] b);
    access(a, b, 8'h00, 5'b00100);
  endtask : io_set

  // Single-bit clear
  task automatic io_clr(input logic [5:0] a, input logic [2:0] b);
    access(a, b, 8'h00, 5'b00010);
  endtask : io_clr

  // Single-bit test
  task automatic io_test(input logic [5:0] a, input logic [2:0] b, output logic v);
    access(a, b, 8'h00, 5'b00001);
    v = bitval_i;
  endtask : io_test

endmodule : lbit_core_model

// [tb/lbit_io_space_tb_top.sv]
`include "lbit_map.svh"

module lbit_io_space_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;                 // System clock
  logic       rst_n;               // Reset, active low
  logic [5:0] addr;                // Core address
  logic       wr, rd, set, clr;    // Core strobes
  logic       test;                // Core test strobe
  logic [2:0] bitn;                // Bit number
  logic [7:0] wdata, rdata;        // Data both ways
  logic       bitval;              // Tested bit
  logic [7:0] pa_pins, adc_low;    // Pin and converter sources
  logic [3:0] pb_pins;             // Port B pins
  logic [7:0] usi_buf;             // Serial buffer source
  logic       usi_done;            // Serial count-done level
  logic [7:0] tmr_set, usi_set;    // Flag set pulses
  logic [7:0] pa_out, pwr_red;     // Observed register outputs
  logic [7:0] tmr_flags, usi_stat; // Observed flag registers
  logic [1:0] usi_strobe;          // Serial strobes
  logic [7:0] d;                   // Last read byte
  logic       v;                   // Last tested bit
  int         fails;               // Mismatches seen
  int         tests_run;           // Comparisons made
  // Fully writable registers
  logic [5:0] full_rw [8] = '{`LBIT_A_DIDR, `LBIT_A_USIDAT, `LBIT_A_PCMASK, `LBIT_A_SCR0,
                              `LBIT_A_SCR1, `LBIT_A_SCR2, `LBIT_A_PADIR, `LBIT_A_PAOUT};

  // Free-running 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  lbit_io_space lbit_io_space_i
  (
    .CLK_I(clk), .RSTN_I(rst_n), .IO_ADDR_I(addr), .IO_WR_I(wr), .IO_RD_I(rd),
    .IO_SET_I(set), .IO_CLR_I(clr), .IO_TEST_I(test), .IO_BIT_I(bitn), .IO_WDATA_I(wdata),
    .IO_RDATA_O(rdata), .IO_BITVAL_O(bitval), .PA_PINS_I(pa_pins), .PB_PINS_I(pb_pins),
    .ADC_RES_LOW_I(adc_low), .USI_BUF_I(usi_buf), .USI_DONE_I(usi_done),
    .TMR1_FLAG_SET_I(tmr_set), .USI_FLAG_SET_I(usi_set), .PA_OUT_O(pa_out), .PA_DIR_O(),
    .PB_OUT_O(), .PB_DIR_O(), .PWR_RED_O(pwr_red), .DIG_IN_DIS_O(), .TMR1_MASK_O(),
    .TMR1_FLAGS_O(tmr_flags), .USI_CTRL_O(), .USI_STAT_O(usi_stat), .USI_DATA_O(),
    .USI_STROBE_O(usi_strobe), .PC_MASK_O(), .NVM_CTRL_O()
  );

  lbit_core_model lbit_core_model_i
  (
    .clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .set_o(set), .clr_o(clr),
    .test_o(test), .bit_o(bitn), .wdata_o(wdata), .rdata_i(rdata), .bitval_i(bitval)
  );

  // Byte comparison, reported at once
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  // Bit comparison, reported at once
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Read a register and compare it
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    lbit_core_model_i.io_rd(a, d);
    chk8(d, exp);
  endtask : rdc

  // One-cycle pulse on both flag set inputs
  task automatic flag_pulse(input logic [7:0] t, input logic [7:0] u);
    @(posedge clk);
    #2;
    tmr_set = t;
    usi_set = u;
    @(posedge clk);
    #2;
    tmr_set = 8'h00;
    usi_set = 8'h00;
  endtask : flag_pulse

  // Single place where the run ends
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Watchdog: the tests need a few hundred cycles, so 20000 means a hang
  initial
  begin
    #(20000 * 25);
    fails++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    fails = 0;
    tests_run = 0;
    rst_n = 1'b0;
    {pa_pins, adc_low, usi_buf, tmr_set, usi_set} = 40'h0;
    pb_pins = 4'h0;
    usi_done = 1'b0;
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    // Everything reads zero out of reset
    for (int a = 0; a <= 28; a++)
      rdc(6'(a), 8'h00);
    // Bit set and clear touch one bit of each fully writable register
    foreach (full_rw[i])
    begin
      lbit_core_model_i.io_wr(full_rw[i], 8'ha5);
      lbit_core_model_i.io_set(full_rw[i], 3'd1);
      lbit_core_model_i.io_clr(full_rw[i], 3'd0);
      lbit_core_model_i.io_clr(full_rw[i], 3'd7);
      rdc(full_rw[i], 8'h26);
    end
    // Partly implemented registers; reserved bits only ever written as zero
    lbit_core_model_i.io_wr(`LBIT_A_PWR, 8'h05);
    lbit_core_model_i.io_set(`LBIT_A_PWR, 3'd3);
    lbit_core_model_i.io_clr(`LBIT_A_PWR, 3'd0);
    chk8(pwr_red, 8'h0c);
    lbit_core_model_i.io_set(`LBIT_A_NVMCTL, 3'd5);
    rdc(`LBIT_A_NVMCTL, 8'h20);
    lbit_core_model_i.io_set(`LBIT_A_PBDIR, 3'd3);
    rdc(`LBIT_A_PBDIR, 8'h08);
    lbit_core_model_i.io_wr(`LBIT_A_PBOUT, 8'h0a);
    rdc(`LBIT_A_PBOUT, 8'h0a);
    lbit_core_model_i.io_set(`LBIT_A_T1MSK, 3'd5);
    lbit_core_model_i.io_set(`LBIT_A_T1MSK, 3'd0);
    rdc(`LBIT_A_T1MSK, 8'h21);
    // Bit tests sample without disturbing the register or the pins
    pa_pins = 8'h5a;
    for (int b = 0; b < 8; b++)
    begin
      lbit_core_model_i.io_test(`LBIT_A_PAOUT, 3'(b), v);
      chk1(v, 1'(8'h26 >> b));
      lbit_core_model_i.io_test(`LBIT_A_PAIN, 3'(b), v);
      chk1(v, pa_pins[b]);
    end
    chk8(pa_out, 8'h26);
    // Bit ops above the bit-accessible range have no effect
    lbit_core_model_i.io_set(6'h3b, 3'd4);
    lbit_core_model_i.io_clr(6'h3b, 3'd1);
    lbit_core_model_i.io_set(6'h20, 3'd0);
    chk8(pa_out, 8'h26);
    chk8(pwr_red, 8'h0c);
    lbit_core_model_i.io_test(6'h3b, 3'd1, v);
    chk1(v, 1'b0);
    // Read-only sources and a reserved hole
    adc_low = 8'hc3;
    usi_buf = 8'h7e;
    pb_pins = 4'h9;
    lbit_core_model_i.io_wr(`LBIT_A_CNVLO, 8'h33);
    rdc(`LBIT_A_CNVLO, 8'hc3);
    rdc(`LBIT_A_USIBUF, 8'h7e);
    rdc(`LBIT_A_PBIN, 8'h09);
    lbit_core_model_i.io_wr(`LBIT_A_RSVD11, 8'h00);
    rdc(`LBIT_A_RSVD11, 8'h00);
    // Timer flags: only implemented ones set, cleared by a one
    flag_pulse(8'hff, 8'hff);
    chk8(tmr_flags, 8'h27);
    lbit_core_model_i.io_wr(`LBIT_A_T1FLG, 8'h01);
    chk8(tmr_flags, 8'h26);
    lbit_core_model_i.io_set(`LBIT_A_T1FLG, 3'd2);
    chk8(tmr_flags, 8'h22);
    lbit_core_model_i.io_clr(`LBIT_A_T1FLG, 3'd5);
    chk8(tmr_flags, 8'h22);
    // Serial status: counter bit set leaves pending flags alone
    chk8(usi_stat, 8'he0);
    lbit_core_model_i.io_set(`LBIT_A_USISTA, 3'd0);
    chk8(usi_stat, 8'he1);
    usi_done = 1'b1;
    rdc(`LBIT_A_USISTA, 8'hf1);
    lbit_core_model_i.io_test(`LBIT_A_USISTA, 3'd4, v);
    chk1(v, 1'b1);
    lbit_core_model_i.io_wr(`LBIT_A_USISTA, 8'h40);
    chk8(usi_stat, 8'ha0);
    // Serial strobes pulse for one cycle and read back as zero
    lbit_core_model_i.io_wr(`LBIT_A_USICTL, 8'hc1);
    chk8({6'h00, usi_strobe}, 8'h01);
    @(posedge clk);
    #2;
    chk8({6'h00, usi_strobe}, 8'h00);
    rdc(`LBIT_A_USICTL, 8'hc0);
    // Second reset in mid-run clears the stored state
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    rst_n = 1'b1;
    chk8(pa_out, 8'h00);
    chk8(tmr_flags, 8'h00);
    // Access right after release must land
    lbit_core_model_i.io_set(`LBIT_A_PAOUT, 3'd3);
    chk8(pa_out, 8'h08);
    give_verdict();
  end

endmodule : lbit_io_space_tb_top
